// ---- core/dmac_top.sv ----
// Two-channel transfer controller: requests, priority, reload and bus sequencing
`timescale 1ns/1ps
module dmac_top
  import dmac_pkg::*;
(
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   single_chip_in,
  input  wire logic                   byte_pin_in,
  input  wire logic [1:0]             enable_wr_in,
  input  wire logic [1:0]             enable_wdata_in,
  input  wire logic [1:0]             req_flag_wr_in,
  input  wire logic [1:0]             req_flag_wdata_in,
  input  wire logic [1:0][1:0]        req_src_sel_in,
  input  wire logic [1:0]             periph_irq_in,
  input  wire logic [1:0]             soft_trig_in,
  input  wire logic [1:0]             external_interrupt_input_in,
  input  wire logic [1:0]             transfer_unit_select_in,
  input  wire logic [1:0]             fwd_sel_in,
  input  wire logic [1:0][ADDR_W-1:0] src_ptr_in,
  input  wire logic [1:0][ADDR_W-1:0] dst_ptr_in,
  input  wire logic [1:0][CNT_W-1:0]  reload_in,
  input  wire logic [1:0][2:0]        src_area_in,
  input  wire logic [1:0][2:0]        dst_area_in,
  input  wire logic [DATA_W-1:0]      bus_rdata_in,
  output logic [ADDR_W-1:0]           bus_addr_out,
  output logic                        bus_rd_out,
  output logic                        bus_wr_out,
  output logic                        bus_byte_out,
  output logic [DATA_W-1:0]           bus_wdata_out,
  output logic                        bus_owned_out,
  output logic [1:0]                  enable_out,
  output logic [1:0]                  req_flag_out,
  output logic [1:0]                  xfer_done_out,
  output logic [1:0][CNT_W-1:0]       count_out,
  output logic [1:0][ADDR_W-1:0]      src_ptr_rd_out,
  output logic [1:0][ADDR_W-1:0]      dst_ptr_rd_out
);

  dmac_regs_t        r;
  dmac_regs_t        next_r;
  logic              bus8;
  logic              unit_byte;
  logic [1:0]        src_acc;
  logic [1:0]        src_coef;
  logic              src_byte;
  logic [1:0]        dst_acc;
  logic [1:0]        dst_coef;
  logic              dst_byte;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [DATA_W-1:0] fifo_out_data;
  logic [1:0]        req_event;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle cost of the channel in flight

  assign bus8      = byte_pin_in && !single_chip_in;
  assign unit_byte = transfer_unit_select_in[r.ch];

  dmac_cost u_src_cost
  (
    .unit_byte_in (unit_byte),
    .bus8_in      (bus8),
    .addr_lsb_in  (r.src_a[0]),
    .area_in      (src_area_in[r.ch]),
    .acc_cnt_out  (src_acc),
    .coef_out     (src_coef),
    .byte_acc_out (src_byte)
  );

  dmac_cost u_dst_cost
  (
    .unit_byte_in (unit_byte),
    .bus8_in      (bus8),
    .addr_lsb_in  (r.dst_a[0]),
    .area_in      (dst_area_in[r.ch]),
    .acc_cnt_out  (dst_acc),
    .coef_out     (dst_coef),
    .byte_acc_out (dst_byte)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read data staged between source and destination phases

  assign fifo_in_valid  = (r.st == ST_HAND);
  assign fifo_out_ready = (r.st == ST_DRAIN);

  dmac_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo
  (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .wr_valid_in  (fifo_in_valid),
    .wr_ready_out (fifo_in_ready),
    .wr_data_in   (r.data),
    .rd_valid_out (fifo_out_valid),
    .rd_ready_in  (fifo_out_ready),
    .rd_data_out  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Request source per channel

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++)
    begin : g_req
      always_comb
      begin
        case (req_src_sel_in[gc])
          SRC_PERIPH:   req_event[gc] = periph_irq_in[gc];
          SRC_SOFT:     req_event[gc] = soft_trig_in[gc];
          SRC_PIN_RISE: req_event[gc] = external_interrupt_input_in[gc]
                                        && !r.pin_q[gc];
          default:      req_event[gc] = !external_interrupt_input_in[gc]
                                        && r.pin_q[gc];
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    logic              start;
    logic              gch;
    logic [ADDR_W-1:0] base;
    start        = 1'b0;
    gch          = 1'b0;
    base         = '0;
    next_r       = r;
    next_r.pin_q = external_interrupt_input_in;
    next_r.done  = '0;

    // No interrupt mask or level takes part in the grant
    if (r.st == ST_IDLE)
    begin
      if (r.en[0] && r.req[0])
      begin
        start = 1'b1;
        gch   = 1'b0;
      end
      else if (r.en[1] && r.req[1])
      begin
        start = 1'b1;
        gch   = 1'b1;
      end
    end

    case (r.st)
      ST_IDLE:
      begin
        if (start)
        begin
          if (r.rel_pend[gch])
          begin
            base = (fwd_sel_in[gch] == FWD_IS_SRC) ? src_ptr_in[gch]
                                                    : dst_ptr_in[gch];
            next_r.fwd[gch]      = base;
            next_r.cnt[gch]      = reload_in[gch];
            next_r.rel_pend[gch] = 1'b0;
          end
          else
          begin
            base = r.fwd[gch];
          end
          next_r.src_a = (fwd_sel_in[gch] == FWD_IS_SRC) ? base : src_ptr_in[gch];
          next_r.dst_a = (fwd_sel_in[gch] == FWD_IS_SRC) ? dst_ptr_in[gch] : base;
          next_r.ch    = gch;
          next_r.part  = 1'b0;
          next_r.tick  = '0;
          next_r.st    = ST_READ;
        end
      end
      ST_READ:
      begin
        if (!r.bus_rd)
        begin
          next_r.bus_rd   = 1'b1;
          next_r.bus_addr = r.src_a;
          next_r.bus_byte = src_byte;
          next_r.tick     = '0;
        end
        else if (r.tick == src_coef - TICK_ONE)
        begin
          if (!src_byte)
          begin
            next_r.data = bus_rdata_in;
          end
          else if (r.part)
          begin
            next_r.data[15:8] = bus_rdata_in[7:0];
          end
          else
          begin
            next_r.data = {BYTE_ZERO, bus_rdata_in[7:0]};
          end
          if (!r.part && src_acc == ACC_TWO)
          begin
            next_r.part     = 1'b1;
            next_r.tick     = '0;
            next_r.bus_addr = r.src_a + ADDR_ONE;
          end
          else
          begin
            next_r.bus_rd = 1'b0;
            next_r.part   = 1'b0;
            next_r.st     = ST_HAND;
          end
        end
        else
        begin
          next_r.tick = r.tick + TICK_ONE;
        end
      end
      ST_HAND:
      begin
        if (fifo_in_ready)
        begin
          next_r.st = ST_DRAIN;
        end
      end
      ST_DRAIN:
      begin
        if (fifo_out_valid)
        begin
          next_r.data = fifo_out_data;
          next_r.st   = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        if (!r.bus_wr)
        begin
          next_r.bus_wr    = 1'b1;
          next_r.bus_addr  = r.dst_a;
          next_r.bus_byte  = dst_byte;
          next_r.bus_wdata = dst_byte ? {BYTE_ZERO, r.data[7:0]} : r.data;
          next_r.tick      = '0;
        end
        else if (r.tick == dst_coef - TICK_ONE)
        begin
          if (!r.part && dst_acc == ACC_TWO)
          begin
            next_r.part      = 1'b1;
            next_r.tick      = '0;
            next_r.bus_addr  = r.dst_a + ADDR_ONE;
            next_r.bus_wdata = {BYTE_ZERO, r.data[15:8]};
          end
          else
          begin
            next_r.bus_wr     = 1'b0;
            next_r.part       = 1'b0;
            next_r.tick       = '0;
            next_r.done[r.ch] = 1'b1;
            next_r.fwd[r.ch]  = r.fwd[r.ch]
                                + ((unit_byte == UNIT_BYTE) ? ADDR_ONE : ADDR_TWO);
            next_r.cnt[r.ch]  = r.cnt[r.ch] - CNT_ONE;
            if (r.cnt[r.ch] == CNT_ONE)
            begin
              next_r.en[r.ch] = 1'b0;
            end
            next_r.st = ST_CPU;
          end
        end
        else
        begin
          next_r.tick = r.tick + TICK_ONE;
        end
      end
      ST_CPU:
      begin
        // Bus handed back for one CPU access between units
        if (r.tick == CPU_SLOT_CYCLES - TICK_ONE)
        begin
          next_r.tick = '0;
          next_r.st   = ST_IDLE;
        end
        else
        begin
          next_r.tick = r.tick + TICK_ONE;
        end
      end
      default:
      begin
        next_r = REGS_RST;
      end
    endcase

    for (int c = 0; c < 2; c++)
    begin
      if ((start && gch == c[0])
          || (req_flag_wr_in[c] && !req_flag_wdata_in[c]))
      begin
        next_r.req[c] = 1'b0;
      end
      // Set beats either clear
      if (req_event[c])
      begin
        next_r.req[c] = 1'b1;
      end
      if (enable_wr_in[c])
      begin
        next_r.en[c] = enable_wdata_in[c];
        if (enable_wdata_in[c])
        begin
          next_r.rel_pend[c] = 1'b1;
        end
      end
      next_r.rd_src[c] = (next_r.en[c] && fwd_sel_in[c] == FWD_IS_SRC)
                         ? next_r.fwd[c] : src_ptr_in[c];
      next_r.rd_dst[c] = (next_r.en[c] && fwd_sel_in[c] != FWD_IS_SRC)
                         ? next_r.fwd[c] : dst_ptr_in[c];
    end

    next_r.busy = (next_r.st != ST_IDLE) && (next_r.st != ST_CPU);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      r <= REGS_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus_addr_out   = r.bus_addr;
  assign bus_rd_out     = r.bus_rd;
  assign bus_wr_out     = r.bus_wr;
  assign bus_byte_out   = r.bus_byte;
  assign bus_wdata_out  = r.bus_wdata;
  assign bus_owned_out  = r.busy;
  assign enable_out     = r.en;
  assign req_flag_out   = r.req;
  assign xfer_done_out  = r.done;
  assign count_out      = r.cnt;
  assign src_ptr_rd_out = r.rd_src;
  assign dst_ptr_rd_out = r.rd_dst;

endmodule : dmac_top

// ---- core/dmac_pkg.sv ----
// Constants, types and state layout shared by the two-channel transfer controller
package dmac_pkg;

  localparam int ADDR_W     = 20;
  localparam int DATA_W     = 16;
  localparam int CNT_W      = 16;
  localparam int FIFO_DEPTH = 8;

  localparam logic [2:0] AREA_INT_NOWAIT = 3'h0;
  localparam logic [2:0] AREA_INT_WAIT   = 3'h1;
  localparam logic [2:0] AREA_PERIPH     = 3'h2;
  localparam logic [2:0] AREA_EXT_NOWAIT = 3'h3;
  localparam logic [2:0] AREA_EXT_WAIT   = 3'h4;
  localparam logic [2:0] AREA_EXT_MUX    = 3'h5;

  localparam logic [1:0] COEF_ONE   = 2'h1;
  localparam logic [1:0] COEF_TWO   = 2'h2;
  localparam logic [1:0] COEF_THREE = 2'h3;
  localparam logic [1:0] ACC_ONE    = 2'h1;
  localparam logic [1:0] ACC_TWO    = 2'h2;
  localparam logic [1:0] TICK_ONE   = 2'h1;

  localparam logic [1:0] SRC_PERIPH   = 2'h0;
  localparam logic [1:0] SRC_SOFT     = 2'h1;
  localparam logic [1:0] SRC_PIN_RISE = 2'h2;
  localparam logic [1:0] SRC_PIN_FALL = 2'h3;

  localparam logic FWD_IS_SRC = 1'b0;
  localparam logic UNIT_BYTE  = 1'b1;

  localparam logic [1:0]        CPU_SLOT_CYCLES = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_ONE        = 20'h00001;
  localparam logic [ADDR_W-1:0] ADDR_TWO        = 20'h00002;
  localparam logic [CNT_W-1:0]  CNT_ONE         = 16'h0001;
  localparam logic [7:0]        BYTE_ZERO       = 8'h00;

  typedef enum logic [5:0]
  {
    ST_IDLE  = 6'h01,
    ST_READ  = 6'h02,
    ST_HAND  = 6'h04,
    ST_DRAIN = 6'h08,
    ST_WRITE = 6'h10,
    ST_CPU   = 6'h20
  } dmac_state_t;

  typedef struct packed {
    dmac_state_t                 st;
    logic                        ch;
    logic                        part;
    logic [1:0]                  tick;
    logic [ADDR_W-1:0]           src_a;
    logic [ADDR_W-1:0]           dst_a;
    logic [DATA_W-1:0]           data;
    logic [ADDR_W-1:0]           bus_addr;
    logic                        bus_rd;
    logic                        bus_wr;
    logic                        bus_byte;
    logic [DATA_W-1:0]           bus_wdata;
    logic                        busy;
    logic [1:0]                  done;
    logic [1:0]                  en;
    logic [1:0]                  rel_pend;
    logic [1:0]                  req;
    logic [1:0]                  pin_q;
    logic [1:0][ADDR_W-1:0]      fwd;
    logic [1:0][ADDR_W-1:0]      rd_src;
    logic [1:0][ADDR_W-1:0]      rd_dst;
    logic [1:0][CNT_W-1:0]       cnt;
  } dmac_regs_t;

  localparam dmac_regs_t REGS_RST = '{st: ST_IDLE, default: '0};

  // Bus cycle stretch per memory area
  function automatic logic [1:0] dmac_area_coef(input logic [2:0] area);
    case (area)
      AREA_INT_NOWAIT: dmac_area_coef = COEF_ONE;
      AREA_INT_WAIT:   dmac_area_coef = COEF_TWO;
      AREA_PERIPH:     dmac_area_coef = COEF_TWO;
      AREA_EXT_NOWAIT: dmac_area_coef = COEF_ONE;
      AREA_EXT_WAIT:   dmac_area_coef = COEF_TWO;
      AREA_EXT_MUX:    dmac_area_coef = COEF_THREE;
      default:         dmac_area_coef = COEF_THREE;
    endcase
  endfunction : dmac_area_coef

endpackage : dmac_pkg

// ---- core/dmac_fifo.sv ----
// Parameterised data FIFO with valid and ready on both sides
`timescale 1ns/1ps
module dmac_fifo
  import dmac_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } dmac_fifo_regs_t;

  dmac_fifo_regs_t       r;
  dmac_fifo_regs_t       next_r;
  logic [WIDTH-1:0]      mem [DEPTH];
  logic                  push;
  logic                  pop;

  assign wr_ready_out = (r.cnt != CW'(DEPTH));
  assign rd_valid_out = (r.cnt != '0);
  assign rd_data_out  = mem[r.rp];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_ready_in && rd_valid_out;

  always_comb
  begin
    next_r = r;
    if (push)
    begin
      next_r.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + PW'(1);
    end
    if (pop)
    begin
      next_r.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + PW'(1);
    end
    if (push && !pop)
    begin
      next_r.cnt = r.cnt + CW'(1);
    end
    else if (pop && !push)
    begin
      next_r.cnt = r.cnt - CW'(1);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Storage without reset
  always_ff @(posedge mclk_in)
  begin
    if (push)
    begin
      mem[r.wp] <= wr_data_in;
    end
  end

endmodule : dmac_fifo

// ---- core/dmac_cost.sv ----
// Access count and cycle stretch for one side of a transfer unit
`timescale 1ns/1ps
module dmac_cost
  import dmac_pkg::*;
(
  input  wire logic       unit_byte_in,
  input  wire logic       bus8_in,
  input  wire logic       addr_lsb_in,
  input  wire logic [2:0] area_in,
  output logic [1:0]      acc_cnt_out,
  output logic [1:0]      coef_out,
  output logic            byte_acc_out
);

  always_comb
  begin
    if (unit_byte_in == UNIT_BYTE)
    begin
      acc_cnt_out = ACC_ONE;
    end
    else if (bus8_in || addr_lsb_in)
    begin
      acc_cnt_out = ACC_TWO;
    end
    else
    begin
      acc_cnt_out = ACC_ONE;
    end
    byte_acc_out = (unit_byte_in == UNIT_BYTE) || (acc_cnt_out == ACC_TWO);
    coef_out     = dmac_area_coef(area_in);
  end

endmodule : dmac_cost

// ---- test/dmac_bus_model.sv ----
// Memory behind the shared bus: every byte holds its own low address bits
`timescale 1ns/1ps
module dmac_bus_model
  import dmac_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out
);
  logic [DATA_W-1:0] last_q = '0;
  logic [DATA_W-1:0] word;

  assign word = {addr_in[7:0] + 8'h01, addr_in[7:0]};

  always @(posedge mclk_in)
    if (rd_in)
      last_q <= word;

  // Released bus shows the inverse of the last value, never a stale copy
  assign rdata_out = rd_in ? word : ~last_q;
endmodule : dmac_bus_model

// ---- test/dmac_top_monitor.sv ----
// Port-level assertions for the two-channel transfer controller
`timescale 1ns/1ps
module dmac_top_monitor
  import dmac_pkg::*;
(
  input wire logic                  mclk_in,
  input wire logic                  rst_n_in,
  input wire logic [1:0]            enable_wr_in,
  input wire logic [1:0]            enable_wdata_in,
  input wire logic [1:0]            req_flag_wr_in,
  input wire logic [1:0]            req_flag_wdata_in,
  input wire logic [1:0][1:0]       req_src_sel_in,
  input wire logic [1:0]            soft_trig_in,
  input wire logic [1:0]            transfer_unit_select_in,
  input wire logic [1:0][2:0]       src_area_in,
  input wire logic                  bus_rd_out,
  input wire logic                  bus_wr_out,
  input wire logic                  bus_byte_out,
  input wire logic [DATA_W-1:0]     bus_wdata_out,
  input wire logic                  bus_owned_out,
  input wire logic [1:0]            enable_out,
  input wire logic [1:0]            req_flag_out,
  input wire logic [1:0]            xfer_done_out,
  input wire logic [1:0][CNT_W-1:0] count_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_strobes_apart: assert property (!(bus_rd_out && bus_wr_out))
    else $error("read and write strobes overlap");
  a_strobe_owned: assert property ((bus_rd_out || bus_wr_out) |-> bus_owned_out)
    else $error("strobe without bus ownership");
  a_done_after_write: assert property (|xfer_done_out |-> $past(bus_wr_out) && !bus_wr_out)
    else $error("done pulse not right after write");
  a_count_step: assert property (xfer_done_out[0]
      |-> count_out[0] == $past(count_out[0]) - CNT_ONE)
    else $error("counter did not drop by one");
  a_byte_upper_zero: assert property (bus_wr_out && bus_byte_out
      |-> bus_wdata_out[15:8] == BYTE_ZERO)
    else $error("byte write upper half not zero");
  a_enable_sets: assert property (enable_wr_in[0] && enable_wdata_in[0] |=> enable_out[0])
    else $error("enable write of one ignored");
  a_soft_sets_flag: assert property (req_src_sel_in[1] == SRC_SOFT
      && soft_trig_in[1] |=> req_flag_out[1])
    else $error("software request did not set flag");
  a_sw_clear_flag: assert property (req_flag_wr_in[1] && !req_flag_wdata_in[1]
      && req_src_sel_in[1] == SRC_SOFT && !soft_trig_in[1] |=> !req_flag_out[1])
    else $error("flag write of zero did not clear");
  a_mux_read_len: assert property ($rose(bus_rd_out) && src_area_in == {AREA_EXT_MUX, AREA_EXT_MUX}
      && transfer_unit_select_in == 2'b11 |-> bus_rd_out [*3] ##1 !bus_rd_out)
    else $error("multiplexed read strobe not three cycles");

  c_unit_done: cover property (xfer_done_out[0]);
  c_second_done: cover property (xfer_done_out[1]);
  c_byte_read: cover property ($rose(bus_rd_out) && bus_byte_out);
endmodule : dmac_top_monitor

bind dmac_top dmac_top_monitor i_dmac_top_monitor (.mclk_in, .rst_n_in, .enable_wr_in,
  .enable_wdata_in, .req_flag_wr_in, .req_flag_wdata_in, .req_src_sel_in, .soft_trig_in,
  .transfer_unit_select_in, .src_area_in, .bus_rd_out, .bus_wr_out, .bus_byte_out,
  .bus_wdata_out, .bus_owned_out, .enable_out, .req_flag_out, .xfer_done_out, .count_out);

// ---- test/dmac_top_test.sv ----
// Self-checking bench for the two-channel transfer controller
`timescale 1ns/1ps
module dmac_top_test
  import dmac_pkg::*;
;
  logic                   mclk_in = 1'b0;
  logic                   rst_n_in, single_chip_in, byte_pin_in;
  logic [1:0]             enable_wr_in, enable_wdata_in, req_flag_wr_in, req_flag_wdata_in;
  logic [1:0][1:0]        req_src_sel_in;
  logic [1:0]             periph_irq_in, soft_trig_in, external_interrupt_input_in;
  logic [1:0]             transfer_unit_select_in, fwd_sel_in;
  logic [1:0][ADDR_W-1:0] src_ptr_in, dst_ptr_in, src_ptr_rd_out, dst_ptr_rd_out;
  logic [1:0][CNT_W-1:0]  reload_in, count_out;
  logic [1:0][2:0]        src_area_in, dst_area_in;
  logic [DATA_W-1:0]      bus_rdata_in, bus_wdata_out, last_wd;
  logic [ADDR_W-1:0]      bus_addr_out, first_ra, last_wa;
  logic                   bus_rd_out, bus_wr_out, bus_byte_out, bus_owned_out;
  logic [1:0]             enable_out, req_flag_out, xfer_done_out;
  logic [1:0]             done_log [$];
  int                     num_errors = 0;
  int                     checks = 0;
  int                     rd_cyc = 0;
  int                     wr_cyc = 0;
  int                     own_cyc = 0;

  dmac_top i_dmac_top (.mclk_in, .rst_n_in, .single_chip_in, .byte_pin_in, .enable_wr_in,
    .enable_wdata_in, .req_flag_wr_in, .req_flag_wdata_in, .req_src_sel_in, .periph_irq_in,
    .soft_trig_in, .external_interrupt_input_in, .transfer_unit_select_in, .fwd_sel_in,
    .src_ptr_in, .dst_ptr_in, .reload_in, .src_area_in, .dst_area_in, .bus_rdata_in,
    .bus_addr_out, .bus_rd_out, .bus_wr_out, .bus_byte_out, .bus_wdata_out, .bus_owned_out,
    .enable_out, .req_flag_out, .xfer_done_out, .count_out, .src_ptr_rd_out, .dst_ptr_rd_out);
  dmac_bus_model i_dmac_bus_model (.mclk_in, .addr_in(bus_addr_out), .rd_in(bus_rd_out),
    .rdata_out(bus_rdata_in));

  always #50 mclk_in = ~mclk_in;

  // Bus activity log, sampled before the edge's own updates
  always @(posedge mclk_in)
  begin
    if (bus_rd_out && rd_cyc == 0)
      first_ra = bus_addr_out;
    rd_cyc += int'(bus_rd_out);
    wr_cyc += int'(bus_wr_out);
    own_cyc += int'(bus_owned_out);
    if (bus_wr_out)
    begin
      last_wa = bus_addr_out;
      last_wd = bus_wdata_out;
    end
    if (xfer_done_out != 2'b00)
      done_log.push_back(xfer_done_out);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : step

  task automatic wr_en(input int ch);
    enable_wr_in[ch] = 1'b1;
    enable_wdata_in[ch] = 1'b1;
    step(1);
    enable_wr_in = 2'b00;
    step(1);
  endtask : wr_en

  task automatic flag_wr(input int ch, input logic v);
    req_flag_wr_in[ch] = 1'b1;
    req_flag_wdata_in[ch] = v;
    step(1);
    req_flag_wr_in = 2'b00;
    step(1);
  endtask : flag_wr

  task automatic kick(input logic [1:0] mask, input int ch);
    rd_cyc = 0;
    wr_cyc = 0;
    own_cyc = 0;
    done_log.delete();
    soft_trig_in = mask;
    step(1);
    soft_trig_in = 2'b00;
    for (int k = 0; k < 200 && xfer_done_out[ch] !== 1'b1; k++)
      step(1);
    check("done pulse", 32'h1, {31'h0, xfer_done_out[ch]});
    step(1);
  endtask : kick

  // Enable write each time, so every unit starts from a fresh reload
  task automatic one_unit(input logic [2:0] area, input logic ub, input logic sc,
                          input logic bp, input logic [ADDR_W-1:0] s);
    src_area_in = {area, area};
    dst_area_in = {area, area};
    transfer_unit_select_in = {ub, ub};
    single_chip_in = sc;
    byte_pin_in = bp;
    src_ptr_in[0] = s;
    wr_en(0);
    kick(2'b01, 0);
  endtask : one_unit

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_areas();
    logic [1:0] coef [6] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h3};
    for (int i = 0; i < 6; i++)
    begin
      one_unit(3'(i), 1'b1, 1'b1, 1'b0, 20'h00101);
      check("read cycles", 32'(coef[i]), rd_cyc);
      check("write cycles", 32'(coef[i]), wr_cyc);
      check("read address", 32'h00101, 32'(first_ra));
      check("write address", 32'h00400, 32'(last_wa));
      check("write data", 32'h0001, 32'(last_wd));
      check("count", 32'h0002, 32'(count_out[0]));
      check("forward readback", 32'h00102, 32'(src_ptr_rd_out[0]));
    end
  endtask : test_areas

  task automatic test_words();
    logic sc, bp, odd, nb;
    for (int i = 0; i < 8; i++)
    begin
      sc = i[2];
      bp = i[1];
      odd = i[0];
      nb = !sc && bp;
      one_unit(AREA_INT_NOWAIT, 1'b0, sc, bp, {19'h00100, odd});
      check("word reads", (nb || odd) ? 2 : 1, rd_cyc);
      check("word writes", nb ? 2 : 1, wr_cyc);
      check("forward step", 32'({19'h00100, odd} + ADDR_TWO), 32'(src_ptr_rd_out[0]));
    end
  endtask : test_words

  task automatic test_flags();
    req_src_sel_in[1] = SRC_SOFT;
    flag_wr(1, 1'b0);
    own_cyc = 0;
    soft_trig_in = 2'b10;
    step(1);
    soft_trig_in = 2'b00;
    step(3);
    check("flag while off", 32'h1, 32'(req_flag_out[1]));
    check("owned while off", 32'h0, own_cyc);
    flag_wr(1, 1'b1);
    check("flag after one", 32'h1, 32'(req_flag_out[1]));
    flag_wr(1, 1'b0);
    check("flag after zero", 32'h0, 32'(req_flag_out[1]));
    req_src_sel_in[1] = SRC_PERIPH;
    flag_wr(1, 1'b0);
    periph_irq_in = 2'b10;
    step(1);
    periph_irq_in = 2'b00;
    step(1);
    check("peripheral request", 32'h1, 32'(req_flag_out[1]));
    for (int m = 2; m < 4; m++)
    begin
      req_src_sel_in[1] = 2'(m);
      external_interrupt_input_in[1] = (m == 3);
      step(2);
      flag_wr(1, 1'b0);
      external_interrupt_input_in[1] = (m == 2);
      step(2);
      check("pin edge request", 32'h1, 32'(req_flag_out[1]));
    end
    req_src_sel_in[1] = SRC_SOFT;
    flag_wr(1, 1'b0);
  endtask : test_flags

  task automatic test_priority();
    src_area_in = '0;
    dst_area_in = '0;
    transfer_unit_select_in = 2'b11;
    wr_en(1);
    wr_en(0);
    kick(2'b11, 1);
    check("grant count", 32'h2, done_log.size());
    check("first grant", 32'h1, 32'(done_log[0]));
    check("second grant", 32'h2, 32'(done_log[1]));
    check("bus owned cycles", 32'd12, own_cyc);
    check("flags at grant", 32'h0, 32'(req_flag_out));
    check("dest forward", 32'h00600, 32'(last_wa));
    check("readback after stop", 32'h00600, 32'(dst_ptr_rd_out[1]));
    check("auto disable", 32'h0, 32'(enable_out[1]));
  endtask : test_priority

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n_in = 1'b0;
    {single_chip_in, byte_pin_in} = 2'b10;
    {enable_wr_in, enable_wdata_in, req_flag_wr_in, req_flag_wdata_in} = '0;
    {periph_irq_in, soft_trig_in, external_interrupt_input_in} = '0;
    req_src_sel_in = {SRC_SOFT, SRC_SOFT};
    transfer_unit_select_in = 2'b11;
    fwd_sel_in = 2'b10;
    src_ptr_in = {20'h00200, 20'h00101};
    dst_ptr_in = {20'h00600, 20'h00400};
    reload_in = {16'h0001, 16'h0003};
    src_area_in = '0;
    dst_area_in = '0;
    step(10);
    check("outputs in reset", 32'h0, 32'({enable_out, req_flag_out, bus_owned_out, bus_wr_out}));
    rst_n_in = 1'b1;
    step(1);
    test_areas();
    test_words();
    test_flags();
    test_priority();
    wrap_up();
  end

  initial
  begin
    repeat (5000) @(posedge mclk_in);
    num_errors++;
    wrap_up();
  end
endmodule : dmac_top_test
